/* spa_top.sv */
// Setpoint alarm output block: two channels, delays, reset modes, registers
// Function
// - Two channels, each with its own enable
// - Signed threshold from -19999 to 99999
// - Unsigned hysteresis up to 59999
// - Values share the display's scaling
// - High or low acting selectable
// - Unbalanced release at threshold minus/plus hysteresis
// - On-delay 0.0 to 599.9 seconds
// - Off-delay 0.0 to 599.9 seconds
// - Auto mode: self release, reset forces off
// - Latch mode: cleared only by reset
// - Delayed latch: pending reset clears at release
// - Power-up latched output off below threshold
// - Power cycle discards pending delayed reset
// - Display reset resets output when qualified
// - Standby holds output off until first trigger
// - Probe failure forces programmed burn-out state
`timescale 1ns/1ps

module spa_top
  import spa_pkg::*;
(
  input  wire logic                        clk_sys,     // System clock, 20 MHz
  input  wire logic                        rst_b,       // Async reset, active low
  input  wire logic [7:0]                  addr,        // Register byte address
  input  wire logic [31:0]                 wdata,       // Write data
  input  wire logic                        wr_stb,      // Write strobe
  input  wire logic                        rd_stb,      // Read strobe
  output logic      [31:0]                 rdata,       // Read data, next cycle
  input  wire logic signed [SPA_VAL_W-1:0] disp_value,  // Displayed input value
  input  wire logic                        value_valid, // New sample strobe
  input  wire logic                        value_shown, // Input value on display
  input  wire logic                        man_reset,   // Key or user input pulse
  input  wire logic                        disp_reset,  // Display reset pulse
  input  wire logic                        rst_src_dsp, // Reset source set to display
  input  wire logic                        probe_fail,  // Sensor open or shorted
  output logic      [1:0]                  alarm_out,   // Setpoint outputs
  output logic                             irq          // Level interrupt
);

  // Configuration registers for both channels
  spa_cfg_type               cfg_r [2];
  logic [SPA_IRQ_W-1:0]      irq_stat_r;   // Sticky event flags
  logic [SPA_IRQ_W-1:0]      irq_mask_r;   // Event mask
  logic [SPA_IRQ_W-1:0]      irq_set;      // Event pulses this cycle
  logic [1:0]                out_r;        // Output state per channel
  logic [1:0]                pend_r;       // Pending delayed reset
  logic [1:0]                armed_r;      // Standby released
  logic [1:0]                first_r;      // First sample after power-up
  logic [23:0]               tick_cnt_r;   // Tick divider
  logic                      tick;         // 0.1 s enable pulse
  logic [SPA_DLY_W-1:0]      dcnt_r [2];   // Delay counters
  logic [1:0]                out_nxt;
  logic [1:0]                pend_nxt;
  logic [1:0]                armed_nxt;

  // Tick divider; one pulse each 0.1 s drives all delays
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 24'h000000;
    end else if (tick) begin
      tick_cnt_r <= 24'h000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h000001;
    end
  end
  assign tick = (tick_cnt_r == 24'(SPA_TICK_CYC - 1));

  // Register writes; out-of-range values clipped so compares stay sane
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr_stb) begin
      for (int i = 0; i < 2; i++) begin
        if (addr == SPA_CTRL0_OFS + 8'(4 * i)) begin
          cfg_r[i].en       <= wdata[SPA_CTL_EN];
          cfg_r[i].low_act  <= wdata[SPA_CTL_LOW];
          cfg_r[i].balanced <= wdata[SPA_CTL_BAL];
          cfg_r[i].mode     <= wdata[SPA_CTL_MODE_LO +: 2];
          cfg_r[i].dsp_rst  <= wdata[SPA_CTL_DSPRST];
          cfg_r[i].standby  <= wdata[SPA_CTL_STBY];
          cfg_r[i].burn_on  <= wdata[SPA_CTL_BURN];
        end
        if (addr == SPA_SETP0_OFS + 8'(4 * i)) begin
          // Threshold clamped into its range
          if ($signed(wdata[17:0]) < SPA_SETP_MIN) begin
            cfg_r[i].setp <= SPA_SETP_MIN;
          end else if ($signed(wdata[17:0]) > SPA_SETP_MAX) begin
            cfg_r[i].setp <= SPA_SETP_MAX;
          end else begin
            cfg_r[i].setp <= $signed(wdata[17:0]);
          end
        end
        if (addr == SPA_HYST0_OFS + 8'(4 * i)) begin
          cfg_r[i].hyst <= (wdata[17:0] > SPA_HYST_MAX) ? SPA_HYST_MAX : wdata[17:0];
        end
        if (addr == SPA_DLY0_OFS + 8'(4 * i)) begin
          cfg_r[i].on_dly  <= (wdata[12:0] > SPA_DLY_MAX) ? SPA_DLY_MAX : wdata[12:0];
          cfg_r[i].off_dly <= (wdata[28:16] > SPA_DLY_MAX) ? SPA_DLY_MAX : wdata[28:16];
        end
      end
    end
  end

  // Per-channel compare and state decisions
  logic [1:0] on_cond;   // Turn-on condition met
  logic [1:0] off_cond;  // Release condition met
  logic [1:0] rst_hit;   // Qualified manual or display reset
  always_comb begin
    logic signed [19:0] sp;
    logic signed [19:0] hy;
    logic signed [19:0] v;
    logic signed [19:0] on_pt;
    logic signed [19:0] off_pt;
    sp = 20'sd0;
    hy = 20'sd0;
    v = 20'sd0;
    on_pt = 20'sd0;
    off_pt = 20'sd0;
    for (int i = 0; i < 2; i++) begin
      sp = 20'(cfg_r[i].setp);
      hy = $signed({2'b00, cfg_r[i].hyst});
      v  = 20'(disp_value);
      // Balanced splits the band; unbalanced puts it all on release side
      if (cfg_r[i].balanced) begin
        on_pt  = cfg_r[i].low_act ? sp - (hy >>> 1) : sp + (hy >>> 1);
        off_pt = cfg_r[i].low_act ? sp + (hy >>> 1) : sp - (hy >>> 1);
      end else begin
        on_pt  = sp;
        off_pt = cfg_r[i].low_act ? sp + hy : sp - hy;
      end
      if (cfg_r[i].low_act) begin
        on_cond[i]  = (v <= on_pt);
        off_cond[i] = (v > off_pt);
      end else begin
        on_cond[i]  = (v >= on_pt);
        off_cond[i] = (v < off_pt);
      end
      rst_hit[i] = man_reset
                 | (disp_reset & cfg_r[i].dsp_rst & rst_src_dsp & value_shown);
    end
  end

  // Delay counters; restart whenever the qualifying condition drops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dcnt_r[0] <= 13'h0000;
      dcnt_r[1] <= 13'h0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!out_r[i] && !on_cond[i]) begin
          dcnt_r[i] <= 13'h0000;
        end else if (out_r[i] && !off_cond[i]) begin
          dcnt_r[i] <= 13'h0000;
        end else if (out_r[i] != out_nxt[i]) begin
          dcnt_r[i] <= 13'h0000;
        end else if (tick && dcnt_r[i] != SPA_DLY_MAX) begin
          dcnt_r[i] <= dcnt_r[i] + 13'h0001;
        end
      end
    end
  end

  // Output next-state logic per reset mode
  always_comb begin
    logic on_due;
    logic off_due;
    on_due = 1'b0;
    off_due = 1'b0;
    out_nxt = out_r;
    pend_nxt = pend_r;
    armed_nxt = armed_r;
    for (int i = 0; i < 2; i++) begin
      on_due  = on_cond[i] && (dcnt_r[i] >= cfg_r[i].on_dly);
      off_due = off_cond[i] && (dcnt_r[i] >= cfg_r[i].off_dly);
      if (!cfg_r[i].en) begin
        out_nxt[i] = 1'b0;
        pend_nxt[i] = 1'b0;
      end else if (value_valid && first_r[i]) begin
        // First sample after power-up: below threshold starts off
        if (disp_value < cfg_r[i].setp) begin
          out_nxt[i] = 1'b0;
        end
        pend_nxt[i] = 1'b0;
      end else if (!out_r[i]) begin
        if (value_valid && on_due && (armed_r[i] || !cfg_r[i].standby)) begin
          out_nxt[i] = 1'b1;
        end
        if (value_valid && on_cond[i]) begin
          armed_nxt[i] = 1'b1;
        end
      end else begin
        case (spa_mode_type'(cfg_r[i].mode))
          SPA_MODE_AUTO: begin
            if (rst_hit[i] || (value_valid && off_due)) begin
              out_nxt[i] = 1'b0;
            end
          end
          SPA_MODE_LATCH: begin
            if (rst_hit[i]) begin
              out_nxt[i] = 1'b0;
            end
          end
          SPA_MODE_LATCH_DLY: begin
            if (rst_hit[i]) begin
              pend_nxt[i] = 1'b1;
            end
            if ((pend_r[i] || rst_hit[i]) && value_valid && off_due) begin
              out_nxt[i] = 1'b0;
              pend_nxt[i] = 1'b0;
            end
          end
          default: begin
            out_nxt[i] = out_r[i];
          end
        endcase
      end
    end
  end

  // Output, pending and standby state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_r   <= 2'h0;
      pend_r  <= 2'h0;
      armed_r <= 2'h0;
      first_r <= 2'h3;
    end else begin
      out_r   <= out_nxt;
      pend_r  <= pend_nxt;
      armed_r <= armed_nxt;
      if (value_valid) begin
        first_r <= 2'h0;
      end
    end
  end

  // Output pins; burn-out state overrides on probe failure
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alarm_out <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!cfg_r[i].en) begin
          alarm_out[i] <= 1'b0;
        end else if (probe_fail) begin
          alarm_out[i] <= cfg_r[i].burn_on;
        end else begin
          alarm_out[i] <= out_nxt[i];
        end
      end
    end
  end

  // Events: on-edge in bits 0/1, off-edge in bits 2/3
  assign irq_set = {out_r & ~out_nxt, ~out_r & out_nxt};

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
    end else begin
      if (wr_stb && addr == SPA_IRQ_OFS) begin
        irq_stat_r <= (irq_stat_r & ~wdata[3:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (wr_stb && addr == SPA_MASK_OFS) begin
        irq_mask_r <= wdata[3:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        SPA_CTRL0_OFS, SPA_CTRL1_OFS: begin
          rdata <= {24'h000000, cfg_r[addr[2]].burn_on, cfg_r[addr[2]].standby,
                    cfg_r[addr[2]].dsp_rst, cfg_r[addr[2]].mode,
                    cfg_r[addr[2]].balanced, cfg_r[addr[2]].low_act, cfg_r[addr[2]].en};
        end
        SPA_SETP0_OFS, SPA_SETP1_OFS: begin
          rdata <= 32'(cfg_r[addr[2]].setp);
        end
        SPA_HYST0_OFS, SPA_HYST1_OFS: begin
          rdata <= {14'h0000, cfg_r[addr[2]].hyst};
        end
        SPA_DLY0_OFS, SPA_DLY1_OFS: begin
          rdata <= {3'h0, cfg_r[addr[2]].off_dly, 3'h0, cfg_r[addr[2]].on_dly};
        end
        SPA_STAT_OFS: begin
          rdata <= {26'h0000000, armed_r, pend_r, alarm_out};
        end
        SPA_IRQ_OFS: begin
          rdata <= {28'h0000000, irq_stat_r};
        end
        SPA_MASK_OFS: begin
          rdata <= {28'h0000000, irq_mask_r};
        end
        default: begin
          rdata <= 32'h00000000;
        end
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // Checks
  a_disabled_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !cfg_r[0].en |=> !alarm_out[0]) else $error("disabled channel 0 drove output");
  a_burn_state: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_r[1].en && probe_fail |=> alarm_out[1] == $past(cfg_r[1].burn_on))
    else $error("burn-out state not applied");
  a_latch_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_r[1].en && out_r[1] && man_reset && !first_r[1]
    && cfg_r[1].mode == 2'(SPA_MODE_LATCH)
    |=> !out_r[1]) else $error("latch reset did not clear");
  a_auto_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_r[0].en && out_r[0] && man_reset && cfg_r[0].mode == 2'(SPA_MODE_AUTO)
    |=> !out_r[0]) else $error("auto reset did not clear");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_r[1].en && out_r[1] && !rst_hit[1] && !first_r[1]
    && cfg_r[1].mode == 2'(SPA_MODE_LATCH) |=> out_r[1]) else $error("latch dropped");
  a_pend_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_r[1].en && out_r[1] && man_reset && !value_valid
    && cfg_r[1].mode == 2'(SPA_MODE_LATCH_DLY) |=> pend_r[1] && out_r[1])
    else $error("delayed reset not pending");
  a_on_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(out_r[0]) |-> $past(dcnt_r[0]) >= $past(cfg_r[0].on_dly))
    else $error("output rose before on-delay");
  a_tick_period: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick |=> !tick [*8]) else $error("tick too frequent");
  a_dsp_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !man_reset && !value_shown |-> rst_hit == 2'h0) else $error("ungated display reset");
  c_turn_on: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(out_r[0]));
  c_delayed_clear: cover property (@(posedge clk_sys) disable iff (!rst_b)
    pend_r[1] ##1 !pend_r[1] && !out_r[1]);
  c_burn_out: cover property (@(posedge clk_sys) disable iff (!rst_b)
    probe_fail && alarm_out[0]);

endmodule

/* spa_pkg.sv */
// Package for the setpoint alarm output block: register map, fields, timing
package spa_pkg;

  // Register word offsets (byte addresses)
  localparam logic [7:0] SPA_CTRL0_OFS   = 8'h00;  // Channel 0 control
  localparam logic [7:0] SPA_CTRL1_OFS   = 8'h04;  // Channel 1 control
  localparam logic [7:0] SPA_SETP0_OFS   = 8'h08;  // Channel 0 threshold
  localparam logic [7:0] SPA_SETP1_OFS   = 8'h0C;  // Channel 1 threshold
  localparam logic [7:0] SPA_HYST0_OFS   = 8'h10;  // Channel 0 hysteresis
  localparam logic [7:0] SPA_HYST1_OFS   = 8'h14;  // Channel 1 hysteresis
  localparam logic [7:0] SPA_DLY0_OFS    = 8'h18;  // Channel 0 on/off delays
  localparam logic [7:0] SPA_DLY1_OFS    = 8'h1C;  // Channel 1 on/off delays
  localparam logic [7:0] SPA_STAT_OFS    = 8'h20;  // Output and pending state
  localparam logic [7:0] SPA_IRQ_OFS     = 8'h24;  // Sticky event flags
  localparam logic [7:0] SPA_MASK_OFS    = 8'h28;  // Event mask

  // Control field positions
  localparam int SPA_CTL_EN      = 0;  // Channel enable
  localparam int SPA_CTL_LOW     = 1;  // 1 = low acting
  localparam int SPA_CTL_BAL     = 2;  // 1 = balanced hysteresis
  localparam int SPA_CTL_MODE_LO = 3;  // Reset mode, two bits
  localparam int SPA_CTL_DSPRST  = 5;  // Reset with display reset
  localparam int SPA_CTL_STBY    = 6;  // Power-up standby
  localparam int SPA_CTL_BURN    = 7;  // Burn-out state
  localparam int SPA_CTL_W       = 8;  // Control width

  // Value widths
  localparam int SPA_VAL_W = 18;  // Signed display value
  localparam int SPA_DLY_W = 13;  // Tenths of a second, up to 5999

  // Range limits of programmed values
  localparam logic signed [17:0] SPA_SETP_MIN = -18'sd19999;
  localparam logic signed [17:0] SPA_SETP_MAX = 18'sd99999;
  localparam logic [17:0]        SPA_HYST_MAX = 18'd59999;
  localparam logic [12:0]        SPA_DLY_MAX  = 13'd5999;

  // Reset values
  localparam logic [7:0] SPA_CTRL_RST = 8'h00;

  // Delay tick: 0.1 s at a 20 MHz clock
  localparam int SPA_CLK_HZ   = 20000000;
  localparam int SPA_TICK_MS  = 100;
  localparam int SPA_TICK_CYC = SPA_CLK_HZ / 1000 * SPA_TICK_MS;

  // Reset modes
  typedef enum logic [1:0] {
    SPA_MODE_AUTO,
    SPA_MODE_LATCH,
    SPA_MODE_LATCH_DLY
  } spa_mode_type;

  // Interrupt bits: per channel on-event and off-event
  localparam int SPA_IRQ_W = 4;

  // One channel's configuration bundle
  typedef struct packed {
    logic                        en;
    logic                        low_act;
    logic                        balanced;
    logic [1:0]                  mode;
    logic                        dsp_rst;
    logic                        standby;
    logic                        burn_on;
    logic signed [SPA_VAL_W-1:0] setp;
    logic [SPA_VAL_W-1:0]        hyst;
    logic [SPA_DLY_W-1:0]        on_dly;
    logic [SPA_DLY_W-1:0]        off_dly;
  } spa_cfg_type;

endpackage

/* spa_src_model.sv */
// Partner model: display value source and operator reset inputs
`timescale 1ns/1ps

module spa_src_model
  import spa_pkg::*;
(
  input  wire logic                   clk_sys,     // System clock
  output logic signed [SPA_VAL_W-1:0] disp_value,  // Sampled value
  output logic                        value_valid, // Sample strobe
  output logic                        value_shown, // Value on display
  output logic                        man_reset,   // Key reset pulse
  output logic                        disp_reset,  // Display reset pulse
  output logic                        rst_src_dsp, // Key set to display
  output logic                        probe_fail   // Sensor failure
);
  // Quiet levels at time zero
  initial begin
    disp_value  = '0;
    value_valid = 1'b0;
    value_shown = 1'b0;
    man_reset   = 1'b0;
    disp_reset  = 1'b0;
    rst_src_dsp = 1'b0;
    probe_fail  = 1'b0;
  end

  // One sample; value is scrambled once its strobe is gone
  task automatic send(input int v);
    @(posedge clk_sys);
    disp_value  <= SPA_VAL_W'(v);
    value_valid <= 1'b1;
    @(posedge clk_sys);
    value_valid <= 1'b0;
    disp_value  <= ~SPA_VAL_W'(v);  // Stale value must not be relied on
  endtask

  // One-cycle pulse: key when k is 0, display reset when 1
  task automatic pulse(input bit k);
    @(posedge clk_sys);
    man_reset  <= !k;
    disp_reset <= k;
    @(posedge clk_sys);
    man_reset  <= 1'b0;
    disp_reset <= 1'b0;
  endtask

  // Level inputs, changed only between samples
  task automatic levels(input bit a, input bit b, input bit p);
    @(posedge clk_sys);
    value_shown <= a;
    rst_src_dsp <= b;
    probe_fail  <= p;
  endtask
endmodule

/* tb_top.sv */
// Testbench: bus tasks, reference model of both channels, directed and random runs
`timescale 1ns/1ps

module tb_top
  import spa_pkg::*;
;
  logic                        clk_sys;    // 20 MHz clock
  logic                        rst_b;      // Reset, active low
  logic [7:0]                  addr;       // Bus address
  logic [31:0]                 wdata;      // Bus write data
  logic                        wr_stb;     // Write strobe
  logic                        rd_stb;     // Read strobe
  logic [31:0]                 rdata;      // Read data
  logic signed [SPA_VAL_W-1:0] disp_value; // From partner
  logic                        value_valid, value_shown, man_reset;
  logic                        disp_reset, rst_src_dsp, probe_fail;
  logic [1:0]                  alarm_out;  // Outputs under test
  logic                        irq;        // Level interrupt
  logic [31:0]                 d;          // Last read word
  int                          errors, compares, cyc;
  // Model state per channel
  int                          s[2], h[2], en[2], lo[2], ba[2], mo[2];
  int                          ds[2], bu[2], out[2], pend[2];
  int                          bv[5] = '{0, 105, 110, 95, 89};
  bit                          first, pf, shown, src;

  spa_src_model u_src (.clk_sys(clk_sys), .disp_value(disp_value),
    .value_valid(value_valid), .value_shown(value_shown), .man_reset(man_reset),
    .disp_reset(disp_reset), .rst_src_dsp(rst_src_dsp), .probe_fail(probe_fail));

  spa_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .disp_value(disp_value),
    .value_valid(value_valid), .value_shown(value_shown), .man_reset(man_reset),
    .disp_reset(disp_reset), .rst_src_dsp(rst_src_dsp), .probe_fail(probe_fail),
    .alarm_out(alarm_out), .irq(irq));

  // Free-running clock
  always #25 clk_sys = ~clk_sys;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Single-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  // Single-cycle read; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Reference decision for one sample
  function automatic void step(int c, int v);
    int w;
    int on;
    int off;
    w   = ba[c] != 0 ? h[c] / 2 : h[c];
    on  = lo[c] != 0 ? v <= s[c] - (ba[c] != 0 ? w : 0) : v >= s[c] + (ba[c] != 0 ? w : 0);
    off = lo[c] != 0 ? v > s[c] + w : v < s[c] - w;
    // Probe failure only masks the pin; the decision state runs on
    if (en[c] == 0) begin
      out[c]  = 0;
      pend[c] = 0;
    end else if (first) begin
      // Power-up sample may only clear
      if (v < s[c]) out[c] = 0;
      pend[c] = 0;
    end else if (on != 0) out[c] = 1;
    else if (off != 0 && (mo[c] == 0 || pend[c] != 0)) begin
      out[c]  = 0;
      pend[c] = 0;
    end
  endfunction

  // Reference reset event: delayed mode only remembers it
  function automatic void kick(int c);
    if (mo[c] == 2) pend[c] = pend[c] | out[c];
    else out[c] = 0;
  endfunction

  // Expected pin level: disabled low, burn-out state on probe failure
  function automatic int ex(int c);
    return en[c] == 0 ? 0 : (pf ? bu[c] : out[c]);
  endfunction

  task automatic look;
    @(posedge clk_sys);
    #1;
    chk("alarm_out", 32'(ex(1) * 2 + ex(0)), 32'(alarm_out));
  endtask

  task automatic smp(input int v);
    u_src.send(v);
    step(0, v);
    step(1, v);
    first = 0;
    look();
  endtask

  // Reset pulse; k set means display reset
  task automatic key(input bit k);
    u_src.pulse(k);
    for (int c = 0; c < 2; c++)
      if (!k || (ds[c] != 0 && src && shown)) kick(c);
    look();
  endtask

  task automatic lv(input bit a, input bit b, input bit p);
    shown = a;
    src   = b;
    pf    = p;
    u_src.levels(a, b, p);
  endtask

  task automatic cfg(input int c, e, l, b, m, dr, u, sv, hv);
    en[c] = e;
    lo[c] = l;
    ba[c] = b;
    mo[c] = m;
    ds[c] = dr;
    bu[c] = u;
    s[c]  = sv;
    h[c]  = hv;
    wr(8'(SPA_CTRL0_OFS + 4 * c), 32'(e << SPA_CTL_EN | l << SPA_CTL_LOW | b << SPA_CTL_BAL
       | m << SPA_CTL_MODE_LO | dr << SPA_CTL_DSPRST | u << SPA_CTL_BURN));
    wr(8'(SPA_SETP0_OFS + 4 * c), 32'(sv));
    wr(8'(SPA_HYST0_OFS + 4 * c), 32'(hv));
  endtask

  // Main sequence
  initial begin
    clk_sys  = 1'b0;
    rst_b    = 1'b0;
    addr     = 8'h00;
    wdata    = 32'h0;
    wr_stb   = 1'b0;
    rd_stb   = 1'b0;
    errors   = 0;
    compares = 0;
    cyc      = 0;
    first    = 1;
    d = $urandom(91874);
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, two unmapped words at the end
    for (int a = 0; a <= 8'h30; a += 4) begin
      rd(8'(a), d);
      chk("reset_reg", 32'h0, d);
    end
    chk("reset_out", 32'h0, 32'({irq, alarm_out}));
    // Out-of-range values are clamped
    wr(SPA_SETP0_OFS, 32'h186A0);
    rd(SPA_SETP0_OFS, d);
    chk("setp_hi", 32'h1869F, d);
    wr(SPA_SETP0_OFS, 32'hFFFFB1E0);
    rd(SPA_SETP0_OFS, d);
    chk("setp_lo", 32'hFFFFB1E1, d);
    wr(SPA_HYST0_OFS, 32'hEA60);
    rd(SPA_HYST0_OFS, d);
    chk("hyst_max", 32'hEA5F, d);
    wr(SPA_DLY0_OFS, 32'h17701770);
    rd(SPA_DLY0_OFS, d);
    chk("dly_max", 32'h176F176F, d);
    wr(SPA_DLY0_OFS, 32'h0);
    // High auto with display reset and burn on; low latch
    cfg(0, 1, 0, 0, 0, 1, 1, 100, 20);
    cfg(1, 1, 1, 0, 1, 0, 0, -50, 10);
    smp(-19999);
    repeat (60) smp(int'($urandom_range(300)) - 100);
    // Interrupt raise, mask, clear
    smp(0);
    wr(SPA_IRQ_OFS, 32'hF);
    wr(SPA_MASK_OFS, 32'h1);
    wr(SPA_STAT_OFS, 32'hF);
    rd(SPA_STAT_OFS, d);
    chk("stat_ro", 32'(out[1] * 2 + out[0]), d & 32'h3);
    chk("irq_idle", 32'h0, 32'(irq));
    smp(150);
    chk("irq_on", 32'h1, 32'(irq));
    wr(SPA_IRQ_OFS, 32'h1);
    rd(SPA_IRQ_OFS, d);
    chk("irq_w1c", 32'h0, d & 32'h1);
    chk("irq_low", 32'h0, 32'(irq));
    smp(0);
    rd(SPA_IRQ_OFS, d);
    chk("irq_offev", 32'h4, d & 32'h4);
    // Manual reset in auto and latch modes
    smp(150);
    key(0);
    smp(0);
    smp(150);
    smp(-100);
    smp(0);
    // Delayed clear: pending until release point
    cfg(1, 1, 1, 0, 2, 0, 0, -50, 10);
    key(0);
    rd(SPA_STAT_OFS, d);
    chk("pending", 32'(pend[1] * 8 + pend[0] * 4 + out[1] * 2 + out[0]), d & 32'hF);
    smp(-60);
    smp(0);
    smp(-100);
    smp(0);
    // Display reset only when qualified
    lv(1, 1, 0);
    smp(150);
    key(1);
    smp(0);
    smp(150);
    lv(0, 1, 0);
    key(1);
    // Balanced band
    cfg(0, 1, 0, 1, 0, 0, 1, 100, 20);
    foreach (bv[i]) smp(bv[i]);
    // Probe failure forces burn state per channel
    lv(0, 0, 1);
    smp(0);
    lv(0, 0, 0);
    // Disabled channel stays inactive
    cfg(0, 0, 0, 0, 0, 0, 1, 100, 20);
    smp(150);
    wrap_up();
  end
endmodule
